// >>> verilog/hazard_pkg.sv
// Purpose: shared types and constants for the pipeline interlock block
// Assumes: one core clock, decode hands over one pre-decoded instruction per slot
// Notes:   register index bit 4 selects the dsp register bank
package hazard_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 5;
  localparam int unsigned MUL_CNT_W   = 3;

  // multiplier busy time after the last memory access, in cycles
  localparam logic [MUL_CNT_W-1:0] MUL_CYC_LONG  = 3'h4;  // 64-bit product
  localparam logic [MUL_CNT_W-1:0] MUL_CYC_SHORT = 3'h2;  // 32-bit product
  localparam logic [MUL_CNT_W-1:0] MUL_CNT_IDLE  = 3'h0;

  localparam logic [REG_W-1:0]  REG_NONE   = 5'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

  // pre-decoded instruction as it travels down the pipe
  typedef struct packed {
    logic             valid;
    logic             mem;          // has a bus transfer in memory_access_stage
    logic             is_load;      // writes dest in writeback_dsp_stage
    logic             is_store;     // stores src in memory_access_stage
    logic             is_mul;       // multiply or multiply-accumulate
    logic             mul_long;     // 64-bit product
    logic             two_ma;       // two memory accesses, e.g. word_multiply_accumulate
    logic             acc_access;   // reads or writes accumulator_low/accumulator_high
    logic             is_dsp_op;    // result appears in writeback_dsp_stage
    logic [REG_W-1:0] dest;
    logic [REG_W-1:0] src;
    logic [REG_W-1:0] addr;         // address pointer register
    logic             uses_addr;
  } instr_t;

  localparam instr_t BUBBLE = '0;

  // one-shot extensions already spent by the instruction in memory_access_stage
  typedef struct packed {
    logic dsp;
    logic ptr;
    logic fetch;
  } ext_done_t;

  typedef enum logic {
    MA_FIRST,
    MA_SECOND
  } ma_phase_t;

endpackage : hazard_pkg

// >>> verilog/mul_busy_counter.sv
// Purpose: tracks how long the multiplier stays busy after a multiply leaves memory access
// Assumes: start only arrives while the counter is idle or just expiring
// Notes:   runs on plain cycles, not pipeline slots
`timescale 1ns/1ps
`default_nettype none
module mul_busy_counter
  import hazard_pkg::*;
(
  input  wire logic                 clk,        // core clock
  input  wire logic                 resetn,     // async reset, active low
  input  wire logic                 start,      // multiply leaves memory access
  input  wire logic                 long_prod,  // 64-bit product
  output logic                      busy_q,     // multiplier access in progress
  output logic                      busy_d      // busy value after next edge
);

  logic [MUL_CNT_W-1:0] cnt_q;
  logic [MUL_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = long_prod ? MUL_CYC_LONG : MUL_CYC_SHORT;
    end else if (cnt_q != MUL_CNT_IDLE) begin
      cnt_d = cnt_q - 3'h1;
    end
    busy_d = (cnt_d != MUL_CNT_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= MUL_CNT_IDLE;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : mul_busy_counter
`default_nettype wire

// >>> verilog/pipeline_hazard_interlock.sv
// What this block does
// - load feeding next store: no stall
// - load data written and re-driven same cycle
// - load in writeback, store in memory access
// - core and dsp registers forward alike
// - word multiply-accumulate: two accesses, two multiplier
// - accumulator move waits for multiplier finish
// - accumulator store waits for multiplier finish
// - multiplier busy four or two cycles
// - colliding multiplier access stretched until free
// - stretched memory access counts as one slot
// - after long multiply, decode stalls one slot
// - multiply and accumulator users are interlocked
// - these also see fetch bus contention
// - dsp result store gets one stall
// - dsp store waits, core alu none
// - loaded address pointer waits for data
//
// Purpose: interlock and store-data forwarding for a five-stage pipeline
// Assumes: decode presents one instruction per slot; fetch_req is from the same clock
// Notes:   hold decisions are registered, so every output comes from a flop
`timescale 1ns/1ps
`default_nettype none
module pipeline_hazard_interlock
  import hazard_pkg::*;
(
  input  wire logic                  clk,            // core clock, 50 MHz
  input  wire logic                  resetn,         // async reset, active low
  input  wire hazard_pkg::instr_t    id_instr,       // instruction in decode_stage
  input  wire logic                  fetch_req,      // fetch wants the bus this slot
  input  wire logic [hazard_pkg::DATA_W-1:0] bus_rdata,  // read data on internal bus
  input  wire logic [hazard_pkg::DATA_W-1:0] reg_rdata,  // store operand from register file
  output hazard_pkg::instr_t         ex_stage_q,     // execute_stage contents
  output hazard_pkg::instr_t         ma_stage_q,     // memory_access_stage contents
  output hazard_pkg::instr_t         wb_stage_q,     // writeback_dsp_stage contents
  output logic                       id_stall_q,     // decode must hold its instruction
  output logic                       ma_hold_q,      // memory access stretched this cycle
  output logic                       mm_busy_q,      // multiplier access running
  output logic                       rf_we_q,        // register write strobe
  output logic [hazard_pkg::REG_W-1:0]  rf_waddr_q,  // register write index
  output logic [hazard_pkg::DATA_W-1:0] rf_wdata_q,  // register write data
  output logic [hazard_pkg::DATA_W-1:0] bus_wdata_q, // store data onto internal bus
  output logic                       fwd_q           // store data comes from the load
);

  import hazard_pkg::*;

  // pipeline state
  instr_t               ex_d;
  instr_t               ma_d;
  instr_t               wb_d;
  ma_phase_t            phase_q;
  ma_phase_t            phase_d;
  ext_done_t            ext_q;
  ext_done_t            ext_d;
  logic                 long_stall_q;
  logic                 long_stall_d;
  logic                 id_stall_d;
  logic                 ma_hold_d;

  // fetch request as seen when the hold was decided
  logic                 fetch_req_q;
  logic                 fetch_req_d;

  // data path state
  logic                 rf_we_d;
  logic [REG_W-1:0]     rf_waddr_d;
  logic [DATA_W-1:0]    rf_wdata_d;
  logic [DATA_W-1:0]    bus_wdata_d;
  logic                 fwd_d;
  logic [DATA_W-1:0]    load_data_q;
  logic [DATA_W-1:0]    load_data_d;

  // multiplier
  logic                 mm_start;
  logic                 mm_busy_d;

  // hold terms evaluated on the state that follows the next edge
  logic                 h_two;
  logic                 h_mul;
  logic                 h_dsp;
  logic                 h_ptr;
  logic                 h_fetch;
  logic                 adv;
  logic                 id_take;

  // the slot advances only when no hold was decided at the last edge
  assign adv     = !ma_hold_q;
  assign id_take = !id_stall_q;

  // a multiply hands off to the multiplier the slot it leaves memory access
  assign mm_start = adv && ma_stage_q.valid && ma_stage_q.is_mul;

  mul_busy_counter u_mul_busy (
    .clk       (clk),
    .resetn    (resetn),
    .start     (mm_start),
    .long_prod (ma_stage_q.mul_long),
    .busy_q    (mm_busy_q),
    .busy_d    (mm_busy_d)
  );

  // stage movement
  always_comb begin
    ex_d    = ex_stage_q;
    ma_d    = ma_stage_q;
    wb_d    = BUBBLE;
    phase_d = phase_q;
    ext_d   = ext_q;
    if (adv) begin
      // an instruction that stays for its second access does not move on
      if (ma_stage_q.valid && ma_stage_q.two_ma && phase_q == MA_FIRST) begin
        phase_d = MA_SECOND;
        ex_d    = ex_stage_q;
        ma_d    = ma_stage_q;
      end else begin
        wb_d    = ma_stage_q;
        ma_d    = ex_stage_q;
        ex_d    = id_take ? id_instr : BUBBLE;
        phase_d = MA_FIRST;
        ext_d   = '0;
      end
    end else begin
      // the held first access of a two-access instruction is its first access;
      // without this step the second access would never be reached and the pipe would lock
      if (ma_stage_q.valid && ma_stage_q.two_ma && phase_q == MA_FIRST) begin
        phase_d = MA_SECOND;
      end

      // a stretched access stays one slot; only the spent extensions are noted
      ext_d.dsp   = ext_q.dsp   | h_dsp_now();
      ext_d.ptr   = ext_q.ptr   | h_ptr_now();
      ext_d.fetch = ext_q.fetch | h_fetch_now();
    end
  end

  // which one-shot extension the current stretched cycle spends
  function automatic logic h_dsp_now();
    h_dsp_now = ma_stage_q.valid && ma_stage_q.is_store && !ext_q.dsp &&
                wb_stage_q.valid && wb_stage_q.is_dsp_op &&
                (ma_stage_q.src == wb_stage_q.dest);
  endfunction : h_dsp_now

  function automatic logic h_ptr_now();
    h_ptr_now = ma_stage_q.valid && ma_stage_q.uses_addr && !ext_q.ptr &&
                wb_stage_q.valid && wb_stage_q.is_load &&
                (ma_stage_q.addr == wb_stage_q.dest);
  endfunction : h_ptr_now

  function automatic logic h_fetch_now();
    h_fetch_now = ma_stage_q.valid && ma_stage_q.mem && !ext_q.fetch &&
                  !h_dsp_now() && !h_ptr_now() && fetch_req_q;
  endfunction : h_fetch_now

  assign fetch_req_d = fetch_req;

  // hold decision for the next cycle, taken on next-state values.
  // deciding one edge early costs a wider cone of logic, but it lets
  // ma_hold_q and id_stall_q leave flops and still mark the stretched
  // cycle itself rather than the one after it.
  // a hold never moves an instruction, so the same instruction is judged
  // again at the next edge; the ext flags stop one-shot extensions from
  // repeating while the multiplier hold simply lasts as long as busy does.
  always_comb begin
    // second access of a two-access instruction keeps earlier stages frozen
    h_two = ma_d.valid && ma_d.two_ma && (phase_d == MA_FIRST);

    // multiplier users wait out the previous multiplier access;
    // a two-access instruction is checked on its second access only
    h_mul = ma_d.valid && (ma_d.is_mul || ma_d.acc_access) &&
            !(ma_d.two_ma && phase_d == MA_FIRST) &&
            mm_busy_d;

    // store of a dsp result right behind the dsp op: one stall;
    // a core alu result is ready after execute and never matches here
    h_dsp = ma_d.valid && ma_d.is_store && !ext_d.dsp &&
            wb_d.valid && wb_d.is_dsp_op &&
            (ma_d.src == wb_d.dest);

    // access through a pointer that the previous load is still filling
    h_ptr = ma_d.valid && ma_d.uses_addr && !ext_d.ptr &&
            wb_d.valid && wb_d.is_load && (ma_d.addr == wb_d.dest);

    // fetch and memory access share the bus; the slot splits once
    h_fetch = ma_d.valid && ma_d.mem && !ext_d.fetch &&
              !h_dsp && !h_ptr && fetch_req_d;

    ma_hold_d = h_mul || h_dsp || h_ptr || h_fetch || h_two;

    // one extra decode slot after a long multiply enters memory access
    long_stall_d = adv && !long_stall_q && ex_stage_q.valid &&
                   ex_stage_q.is_mul && ex_stage_q.mul_long;
    id_stall_d   = ma_hold_d || long_stall_d;
  end

  // load data and store-data forwarding
  always_comb begin
    load_data_d = load_data_q;
    rf_we_d     = 1'b0;
    rf_waddr_d  = REG_NONE;
    rf_wdata_d  = rf_wdata_q;
    bus_wdata_d = bus_wdata_q;
    fwd_d       = 1'b0;
    // load data is on the bus while the load sits in memory access
    if (adv && ma_stage_q.valid && ma_stage_q.is_load) begin
      load_data_d = bus_rdata;
    end
    if (adv && ma_stage_q.valid && ma_stage_q.is_load &&
        !(ma_stage_q.two_ma && phase_q == MA_FIRST)) begin
      rf_we_d    = 1'b1;
      rf_waddr_d = ma_stage_q.dest;
      rf_wdata_d = bus_rdata;
    end
    // the store entering memory access reads the load's data directly,
    // whichever register bank the index names
    if (adv && !(ma_stage_q.two_ma && phase_q == MA_FIRST) &&
        ex_stage_q.valid && ex_stage_q.is_store) begin
      if (ma_stage_q.valid && ma_stage_q.is_load &&
          ma_stage_q.dest == ex_stage_q.src) begin
        fwd_d       = 1'b1;
        bus_wdata_d = bus_rdata;
      end else begin
        bus_wdata_d = reg_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ex_stage_q   <= BUBBLE;
      ma_stage_q   <= BUBBLE;
      wb_stage_q   <= BUBBLE;
      phase_q      <= MA_FIRST;
      ext_q        <= '0;
      long_stall_q <= 1'b0;
      id_stall_q   <= 1'b0;
      ma_hold_q    <= 1'b0;
      fetch_req_q  <= 1'b0;
      load_data_q  <= DATA_ZERO;
      rf_we_q      <= 1'b0;
      rf_waddr_q   <= REG_NONE;
      rf_wdata_q   <= DATA_ZERO;
      bus_wdata_q  <= DATA_ZERO;
      fwd_q        <= 1'b0;
    end else begin
      ex_stage_q   <= ex_d;
      ma_stage_q   <= ma_d;
      wb_stage_q   <= wb_d;
      phase_q      <= phase_d;
      ext_q        <= ext_d;
      long_stall_q <= long_stall_d;
      id_stall_q   <= id_stall_d;
      ma_hold_q    <= ma_hold_d;
      fetch_req_q  <= fetch_req_d;
      load_data_q  <= load_data_d;
      rf_we_q      <= rf_we_d;
      rf_waddr_q   <= rf_waddr_d;
      rf_wdata_q   <= rf_wdata_d;
      bus_wdata_q  <= bus_wdata_d;
      fwd_q        <= fwd_d;
    end
  end

endmodule : pipeline_hazard_interlock
`default_nettype wire

// >>> verification/hazard_checker.sv
// Purpose: port-level checks on the pipeline interlock block
// Assumes: one clock domain, async active-low reset
// Notes:   holds are registered, so ma_hold_q marks the stretched cycle itself
`timescale 1ns/1ps
`default_nettype none
module hazard_checker
  import hazard_pkg::*;
(
  input wire logic                  clk,         // core clock
  input wire logic                  resetn,      // async reset, active low
  input wire hazard_pkg::instr_t    ex_stage_q,  // execute contents
  input wire hazard_pkg::instr_t    ma_stage_q,  // memory access contents
  input wire hazard_pkg::instr_t    wb_stage_q,  // writeback contents
  input wire logic                  id_stall_q,  // decode hold
  input wire logic                  ma_hold_q,   // memory access stretched
  input wire logic                  mm_busy_q,   // multiplier running
  input wire logic                  rf_we_q,     // register write strobe
  input wire logic [REG_W-1:0]      rf_waddr_q,  // register write index
  input wire logic [DATA_W-1:0]     rf_wdata_q,  // register write data
  input wire logic [DATA_W-1:0]     bus_wdata_q, // store data
  input wire logic                  fwd_q        // forwarded store
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_FWD_DATA: assert property (fwd_q |-> rf_we_q && rf_wdata_q == bus_wdata_q)
    else $error("forwarded store data differs from load data");
  AST_FWD_STAGES: assert property (fwd_q |-> wb_stage_q.is_load && ma_stage_q.is_store &&
    ma_stage_q.src == wb_stage_q.dest) else $error("forward without load in writeback and store in access");
  AST_WE_ADDR: assert property (rf_we_q |-> rf_waddr_q == wb_stage_q.dest)
    else $error("register write index not the writeback destination");
  AST_HOLD_FREEZE: assert property (ma_hold_q |=> $stable(ex_stage_q) && $stable(ma_stage_q))
    else $error("earlier stages moved during a hold");
  AST_BUSY_LONG: assert property ($rose(mm_busy_q) && wb_stage_q.mul_long |-> mm_busy_q[*4])
    else $error("long product busy shorter than four cycles");
  AST_BUSY_SHORT: assert property ($rose(mm_busy_q) && !wb_stage_q.mul_long |-> mm_busy_q[*2])
    else $error("short product busy shorter than two cycles");
  AST_MUL_WAIT: assert property (mm_busy_q && ma_stage_q.valid && (ma_stage_q.acc_access || ma_stage_q.is_mul)
    |-> ma_hold_q) else $error("multiplier user left memory access while busy");
  AST_DSP_STORE: assert property ($changed(ma_stage_q) && ma_stage_q.valid && ma_stage_q.is_store &&
    wb_stage_q.valid && wb_stage_q.is_dsp_op && ma_stage_q.src == wb_stage_q.dest |-> ma_hold_q)
    else $error("dsp result store not stretched");
  AST_PTR_WAIT: assert property ($changed(ma_stage_q) && ma_stage_q.valid && ma_stage_q.uses_addr &&
    wb_stage_q.valid && wb_stage_q.is_load && ma_stage_q.addr == wb_stage_q.dest |-> ma_hold_q)
    else $error("loaded pointer used without waiting");
  AST_LONG_ID: assert property ($changed(ma_stage_q) && ma_stage_q.valid && ma_stage_q.mul_long
    |-> ##[0:1] id_stall_q) else $error("no decode stall after long multiply");

  COV_FWD: cover property (fwd_q);
  COV_HOLD: cover property ($rose(ma_hold_q));
  COV_BUSY: cover property ($rose(mm_busy_q));
endmodule : hazard_checker

bind pipeline_hazard_interlock hazard_checker u_chk (.clk(clk), .resetn(resetn), .ex_stage_q(ex_stage_q),
  .ma_stage_q(ma_stage_q), .wb_stage_q(wb_stage_q), .id_stall_q(id_stall_q), .ma_hold_q(ma_hold_q),
  .mm_busy_q(mm_busy_q), .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q), .rf_wdata_q(rf_wdata_q),
  .bus_wdata_q(bus_wdata_q), .fwd_q(fwd_q));
`default_nettype wire

// >>> verification/pipeline_hazard_interlock_tb.sv
// Purpose: self-checking bench for the pipeline interlock block
// Assumes: inputs change at the falling edge, outputs counted at the rising edge
// Notes:   each test issues one or two instructions and drains the pipe
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module pipeline_hazard_interlock_tb;
  import hazard_pkg::*;
  typedef struct packed { logic fwd; logic [REG_W-1:0] a; logic [DATA_W-1:0] d; } note_t;
  localparam logic [7:0] LD = 8'hC0, ST = 8'hA0, MULL = 8'h98, MULS = 8'h90;
  localparam logic [7:0] MACW = 8'h94, ACC = 8'h82, ACCST = 8'hA2, DSP = 8'h01, MEM = 8'h80;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  instr_t            id_instr = BUBBLE;
  logic              fetch_req = 1'b0;
  logic [DATA_W-1:0] bus_rdata = DATA_ZERO;
  logic [DATA_W-1:0] reg_rdata = DATA_ZERO;
  instr_t            ex_stage_q, ma_stage_q, wb_stage_q;
  logic              id_stall_q, ma_hold_q, mm_busy_q, rf_we_q, fwd_q;
  logic [REG_W-1:0]  rf_waddr_q;
  logic [DATA_W-1:0] rf_wdata_q, bus_wdata_q;
  int                num_errors = 0, compares = 0, hold_cnt = 0, busy_cnt = 0;
  note_t             notes[$];
  note_t             n;
  logic [REG_W-1:0]  d;

  always #10 clk = ~clk;

  pipeline_hazard_interlock u_dut (.clk(clk), .resetn(resetn), .id_instr(id_instr), .fetch_req(fetch_req),
    .bus_rdata(bus_rdata), .reg_rdata(reg_rdata), .ex_stage_q(ex_stage_q), .ma_stage_q(ma_stage_q),
    .wb_stage_q(wb_stage_q), .id_stall_q(id_stall_q), .ma_hold_q(ma_hold_q), .mm_busy_q(mm_busy_q),
    .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q), .rf_wdata_q(rf_wdata_q), .bus_wdata_q(bus_wdata_q),
    .fwd_q(fwd_q));

  // reading at the rising edge sees the values of the cycle just ending
  always @(posedge clk) begin
    if (ma_hold_q === 1'b1) hold_cnt++;
    if (mm_busy_q === 1'b1) busy_cnt++;
    if (rf_we_q === 1'b1 && wb_stage_q.is_load === 1'b1) begin
      if (notes.size() == 0) begin
        num_errors++;
        $display("unexpected load write: expected none seen %0h", rf_waddr_q);
      end else begin
        n = notes.pop_front();
        `CHK("fwd", n.fwd, fwd_q)
        `CHK("waddr", n.a, rf_waddr_q)
        `CHK("wdata", n.d, rf_wdata_q)
        `CHK("bus_wdata", n.fwd ? n.d : reg_rdata, bus_wdata_q)
      end
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic bound(input int k);
    if (k >= 50) begin
      num_errors++;
      $display("unexpected wait: expected below 50 seen %0d", k);
      close_out();
    end
  endtask : bound

  function automatic instr_t mk(input logic [7:0] f, input logic [4:0] dd, s, a, input logic u);
    return instr_t'({1'b1, f, dd, s, a, u});
  endfunction : mk

  // decode keeps the offer stable while stalled; it is taken at the next unstalled edge
  task automatic issue(input instr_t i);
    int k;
    id_instr = i;
    k = 0;
    while (id_stall_q !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    bound(k);
    @(negedge clk);
  endtask : issue

  task automatic run(input instr_t a, b, input int hx, bx, input logic f, input string nm);
    int h0;
    int b0;
    int k;
    h0 = hold_cnt;
    b0 = busy_cnt;
    fetch_req = f;
    issue(a);
    issue(b);
    id_instr = BUBBLE;
    k = 0;
    while ((ex_stage_q.valid | ma_stage_q.valid | wb_stage_q.valid | mm_busy_q) !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    bound(k);
    fetch_req = 1'b0;
    if (hx < 0) `CHK("holds", 1'b1, hold_cnt != h0)
    else `CHK("holds", hx, hold_cnt - h0)
    `CHK("busy", bx, busy_cnt - b0)
    `CHK("queue", 0, notes.size())
    $display("test %s done", nm);
  endtask : run

  initial begin
    void'($urandom(51628));
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    for (int r = 0; r < 4; r++) begin
      d = {r[0], 4'($urandom_range(15, 1))};
      bus_rdata = $urandom;
      reg_rdata = $urandom;
      notes.push_back('{r < 2, d, bus_rdata});
      run(mk(LD, d, 0, 0, 0), mk(ST, 0, (r < 2) ? d : d ^ 5'h01, 0, 0), 0, 0, 1'b0, "load store");
    end
    notes.push_back('{1'b0, 5'h04, bus_rdata});
    run(mk(LD, 4, 0, 0, 0), mk(MEM, 0, 0, 4, 1), 1, 0, 1'b0, "pointer");
    run(mk(DSP, 6, 0, 0, 0), mk(ST, 0, 6, 0, 0), 1, 0, 1'b0, "dsp store");
    run(mk(8'h00, 6, 0, 0, 0), mk(ST, 0, 6, 0, 0), 0, 0, 1'b0, "alu store");
    run(mk(MACW, 0, 1, 2, 1), BUBBLE, 1, 2, 1'b0, "mac word");
    run(mk(MULL, 0, 1, 2, 0), mk(MULL, 0, 3, 4, 0), -1, 8, 1'b0, "mul mul");
    run(mk(MULS, 0, 1, 2, 0), mk(ACC, 7, 0, 0, 0), -1, 2, 1'b0, "mul acc move");
    run(mk(MACW, 0, 1, 2, 1), mk(ACCST, 0, 0, 5, 1), -1, 2, 1'b0, "mac acc store");
    run(mk(ST, 0, 1, 0, 0), BUBBLE, 1, 0, 1'b1, "fetch contention");
    close_out();
  end
endmodule : pipeline_hazard_interlock_tb
`default_nettype wire
